// ==== rtl/power_budget_capability.sv ====
// Power budgeting extended capability register block.
// Assumes single-cycle config reads/writes on MCLK; read data is
// registered and valid one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module power_budget_capability
    import budget_pkg::*;
#(
    parameter budget_pkg::descriptor_t SUSTAINED_DEFAULT = '{RAIL_RESET, TYPE_SUSTAINED, PMST_RESET, SUB_RESET,
                                                             SCALE_RESET, BASE_RESET}
) (
    // Clock and reset
    input  wire logic                     MCLK,
    input  wire logic                     RESETN,
    // Configuration access
    input  wire logic                     CFG_WR,
    input  wire logic                     CFG_RD,
    input  wire logic [11:0]              CFG_ADDR,
    input  wire logic [3:0]               CFG_BE,
    input  wire logic [31:0]              CFG_WDATA,
    output logic      [31:0]              CFG_RDATA,
    output logic                          CFG_RVALID,
    // EEPROM auto-load
    input  wire logic                     LOAD_MAX,
    input  wire budget_pkg::descriptor_t  LOAD_MAX_VAL,
    input  wire logic                     LOAD_SUS,
    input  wire budget_pkg::descriptor_t  LOAD_SUS_VAL,
    input  wire logic                     LOAD_ALLOC,
    input  wire logic                     LOAD_ALLOC_VAL
);
    logic        rst_meta_q;
    logic        rst_n_q;
    logic [7:0]  sel_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    budget_if    link ();

    // Reset release synchroniser; assertion stays asynchronous
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    budget_store #(
        .SUSTAINED_DEFAULT (SUSTAINED_DEFAULT)
    ) u_store (
        .clk            (MCLK),
        .rst_n          (rst_n_q),
        .load_max       (LOAD_MAX),
        .load_max_val   (LOAD_MAX_VAL),
        .load_sus       (LOAD_SUS),
        .load_sus_val   (LOAD_SUS_VAL),
        .load_alloc     (LOAD_ALLOC),
        .load_alloc_val (LOAD_ALLOC_VAL),
        .bus            (link.store)
    );

    // Selector: only byte lane 0 holds storage, upper lanes are dropped
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_q <= SEL_RESET;
        end else if (CFG_WR && CFG_ADDR == OFF_SELECTOR && CFG_BE[0]) begin
            sel_q <= CFG_WDATA[7:0];
        end
    end
    assign link.selector = sel_q;

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0;
        case (CFG_ADDR)
            OFF_CAP_HEADER: begin
                rdata_d[CAP_ID_LSB +: 16]  = CAP_ID_VALUE;
                rdata_d[CAP_VER_LSB +: 4]  = CAP_VERSION_VALUE;
                rdata_d[NEXT_CAP_LSB +: 12] = NEXT_CAP_VALUE;
            end
            OFF_SELECTOR: begin
                rdata_d[7:0] = sel_q;
            end
            OFF_DESCRIPTOR: begin
                rdata_d[BASE_LSB +: 8] = link.descriptor.base;
                rdata_d[SCALE_LSB +: 2] = link.descriptor.scale;
                rdata_d[SUB_LSB +: 3]  = link.descriptor.sub_state;
                rdata_d[PMST_LSB +: 2] = link.descriptor.pm_state;
                rdata_d[TYPE_LSB +: 3] = link.descriptor.optype;
                rdata_d[RAIL_LSB +: 3] = link.descriptor.rail;
            end
            OFF_ALLOC_FLAGS: begin
                rdata_d[0] = link.alloc;
            end
            default: rdata_d = 32'h0;
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q  <= 32'h0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= CFG_RD;
            rdata_q  <= CFG_RD ? rdata_d : 32'h0;
        end
    end

    assign CFG_RDATA  = rdata_q;
    assign CFG_RVALID = rvalid_q;
endmodule : power_budget_capability
`default_nettype wire

// ==== rtl/budget_pkg.sv ====
// Package for the power budgeting capability register block.
// Assumes a 32-bit configuration access port on the config clock.
package budget_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CAP_HEADER     = 12'h20c;
    localparam logic [11:0] OFF_SELECTOR       = 12'h210;
    localparam logic [11:0] OFF_DESCRIPTOR     = 12'h214;
    localparam logic [11:0] OFF_ALLOC_FLAGS    = 12'h218;
    // Capability header fields
    localparam logic [15:0] CAP_ID_VALUE       = 16'h0004;
    localparam logic [3:0]  CAP_VERSION_VALUE  = 4'h1;
    localparam logic [11:0] NEXT_CAP_VALUE     = 12'h000;
    localparam int          CAP_ID_LSB         = 0;
    localparam int          CAP_VER_LSB        = 16;
    localparam int          NEXT_CAP_LSB       = 20;
    // Selector
    localparam logic [7:0]  SEL_RESET          = 8'h00;
    localparam logic [7:0]  SEL_D0_MAX         = 8'h00;
    localparam logic [7:0]  SEL_D0_SUSTAINED   = 8'h01;
    // Descriptor field positions
    localparam int          BASE_LSB           = 0;
    localparam int          SCALE_LSB          = 8;
    localparam int          SUB_LSB            = 10;
    localparam int          PMST_LSB           = 13;
    localparam int          TYPE_LSB           = 15;
    localparam int          RAIL_LSB           = 18;
    // Descriptor and allocation flag reset values
    localparam logic [7:0]  BASE_RESET         = 8'h04;
    localparam logic [1:0]  SCALE_RESET        = 2'h0;
    localparam logic [2:0]  SUB_RESET          = 3'h0;
    localparam logic [1:0]  PMST_RESET         = 2'h0;
    localparam logic [2:0]  TYPE_RESET         = 3'h7;
    localparam logic [2:0]  TYPE_SUSTAINED     = 3'h1;
    localparam logic [2:0]  RAIL_RESET         = 3'h2;
    localparam logic        ALLOC_RESET        = 1'b0;

    // One budget descriptor
    typedef struct packed {
        logic [2:0] rail;
        logic [2:0] optype;
        logic [1:0] pm_state;
        logic [2:0] sub_state;
        logic [1:0] scale;
        logic [7:0] base;
    } descriptor_t;
endpackage : budget_pkg

// ==== rtl/budget_if.sv ====
// Carrier between the register block and its descriptor store.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface budget_if;
    import budget_pkg::*;
    logic [7:0]  selector;     // Current entry selector
    descriptor_t descriptor;   // Descriptor for that selector
    logic        alloc;        // System allocated flag
    modport store (input selector, output descriptor, output alloc);
    modport regs  (output selector, input descriptor, input alloc);
endinterface : budget_if
`default_nettype wire

// ==== rtl/budget_store.sv ====
// Descriptor store: holds the maximum and sustained entries and the
// allocation flag, reloadable from the EEPROM auto-load port.
// Assumes the load strobe comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module budget_store
    import budget_pkg::*;
#(
    parameter descriptor_t SUSTAINED_DEFAULT = '{RAIL_RESET, TYPE_SUSTAINED, PMST_RESET, SUB_RESET, SCALE_RESET,
                                                 BASE_RESET}
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load_max,
    input  wire descriptor_t load_max_val,
    input  wire logic        load_sus,
    input  wire descriptor_t load_sus_val,
    input  wire logic        load_alloc,
    input  wire logic        load_alloc_val,
    budget_if.store          bus
);
    descriptor_t max_q;
    descriptor_t sus_q;
    logic        alloc_q;

    // Maximum entry; sub state and rail stay at their default codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            max_q <= '{RAIL_RESET, TYPE_RESET, PMST_RESET, SUB_RESET, SCALE_RESET, BASE_RESET};
        end else if (load_max) begin
            max_q           <= load_max_val;
            max_q.sub_state <= SUB_RESET;
            max_q.rail      <= RAIL_RESET;
        end
    end

    // Sustained entry is fully configurable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sus_q <= SUSTAINED_DEFAULT;
        end else if (load_sus) begin
            sus_q <= load_sus_val;
        end
    end

    // System allocated flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alloc_q <= ALLOC_RESET;
        end else if (load_alloc) begin
            alloc_q <= load_alloc_val;
        end
    end

    // Descriptor follows the selector with no delay
    always_comb begin
        case (bus.selector)
            SEL_D0_MAX:       bus.descriptor = max_q;
            SEL_D0_SUSTAINED: bus.descriptor = sus_q;
            default:          bus.descriptor = '0;
        endcase
    end
    assign bus.alloc = alloc_q;
endmodule : budget_store
`default_nettype wire

// ==== verif/budget_props.sv ====
// Port checker for the power budgeting register block.
// Assumes reads are answered on the MCLK edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module budget_props (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RESETN,
    // Configuration access
    input wire logic        CFG_WR,
    input wire logic        CFG_RD,
    input wire logic [11:0] CFG_ADDR,
    input wire logic [3:0]  CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic        CFG_RVALID
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // Read and selector write steps
    sequence rd_at(logic [11:0] a); CFG_RD && CFG_ADDR == a; endsequence
    sequence sel_wr; CFG_WR && CFG_ADDR == 12'h210 && CFG_BE[0]; endsequence
    a_read_answer: assert property (CFG_RD |=> CFG_RVALID) else $error("no answer");
    a_idle_quiet: assert property (!CFG_RD |=> !CFG_RVALID && CFG_RDATA == 0) else $error("idle data");
    a_cap_header: assert property (rd_at(12'h20c) |=> CFG_RDATA == 32'h00010004) else $error("header");
    a_sel_echo: assert property (sel_wr ##1 rd_at(12'h210) |=> CFG_RDATA[7:0] == $past(CFG_WDATA[7:0], 2))
        else $error("selector");
    a_sel_upper: assert property (rd_at(12'h210) |=> CFG_RDATA[31:8] == 0) else $error("sel upper");
    a_unsupported_zero: assert property (sel_wr ##0 CFG_WDATA[7:1] != 0 ##1 rd_at(12'h214) |=> CFG_RDATA == 0)
        else $error("unsupported");
    a_desc_upper: assert property (rd_at(12'h214) |=> CFG_RDATA[31:21] == 0) else $error("desc upper");
    a_alloc_upper: assert property (rd_at(12'h218) |=> CFG_RDATA[31:1] == 0) else $error("alloc upper");
endmodule : budget_props
`default_nettype wire

// ==== verif/cfg_host.sv ====
// Host model: one config request per call on MCLK.
// Assumes the caller paces requests; calls in a row go back to back.
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
    // Clock
    input wire logic    MCLK,
    // Configuration access
    output logic        CFG_WR,
    output logic        CFG_RD,
    output logic [11:0] CFG_ADDR,
    output logic [3:0]  CFG_BE,
    output logic [31:0] CFG_WDATA
);
    initial {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = '0;
    // Idle data keeps moving so a stale word never passes for a write
    task automatic op(input logic w, r, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge MCLK);
        CFG_WR <= w;
        CFG_RD <= r;
        CFG_ADDR <= a;
        CFG_BE <= b;
        CFG_WDATA <= w ? d : $urandom();
    endtask : op
endmodule : cfg_host
`default_nettype wire

// ==== verif/power_budget_capability_tb.sv ====
// Self-checking bench for the power budgeting register block.
// Assumes the host model makes config cycles; loads are bench pulses.
`timescale 1ns/1ps
`default_nettype none
bind power_budget_capability budget_props u_budget_props (.MCLK(MCLK), .RESETN(RESETN), .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID));
module power_budget_capability_tb;
    import budget_pkg::*;
    localparam descriptor_t SUS = '{3'h5, 3'h1, 2'h3, 3'h2, 2'h1, 8'h9a};
    logic        clk = 0, rst_n = 0, lmax = 0, lsus = 0, lal = 0, lalv = 0, wr, rd, rv;
    descriptor_t lmaxv = '0, lsusv = '0, dm;
    logic [11:0] ad;
    logic [3:0]  be;
    logic [31:0] wd, rdat, expq[$];
    int          n_mismatch = 0, check_count = 0, cyc = 0;
    cfg_host u_cfg_host (.MCLK(clk), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(ad), .CFG_BE(be), .CFG_WDATA(wd));
    power_budget_capability #(.SUSTAINED_DEFAULT(SUS)) u_power_budget_capability (.MCLK(clk), .RESETN(rst_n),
        .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(ad), .CFG_BE(be), .CFG_WDATA(wd), .CFG_RDATA(rdat),
        .CFG_RVALID(rv), .LOAD_MAX(lmax), .LOAD_MAX_VAL(lmaxv), .LOAD_SUS(lsus), .LOAD_SUS_VAL(lsusv),
        .LOAD_ALLOC(lal), .LOAD_ALLOC_VAL(lalv));
    initial forever #2.5 clk = ~clk;
    task automatic test_done;
        // A read that never came back leaves its note behind
        if (expq.size() != 0) begin
            n_mismatch++;
            $display("[ERR] pending_reads exp 0 got %0d", expq.size());
        end
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Note the expected word, then issue the read
    task automatic rd_exp(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        u_cfg_host.op(1'b0, 1'b1, a, 4'h0, 32'h0);
    endtask : rd_exp
    task automatic wr_sel(input logic [31:0] d, input logic [3:0] b);
        u_cfg_host.op(1'b1, 1'b0, 12'h210, b, d);
    endtask : wr_sel
    // Oldest note against each answered read; an empty queue fails
    always @(posedge clk) if (rv === 1'b1) chk("rdata", expq.size() ? expq.pop_front() : 'x, rdat);
    // Hang guard, well beyond the roughly 75 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h4c71));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        dm = '{3'h2, 3'h7, 2'h0, 3'h0, 2'h0, 8'h04};
        rd_exp(12'h20c, 32'h00010004);
        rd_exp(12'h210, 32'h0);
        rd_exp(12'h214, {11'h0, dm});
        rd_exp(12'h218, 32'h0);
        wr_sel(32'hffffff01, 4'hf);
        rd_exp(12'h210, 32'h1);
        rd_exp(12'h214, {11'h0, SUS});
        wr_sel(32'h0, 4'he);
        rd_exp(12'h210, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr_sel(i == 0 ? 32'hff : 32'h2 + $urandom_range(253), 4'h1);
            rd_exp(12'h214, 32'h0);
        end
        // Read-only words shrug off writes
        u_cfg_host.op(1'b1, 1'b0, 12'h20c, 4'hf, 32'hffffffff);
        u_cfg_host.op(1'b1, 1'b0, 12'h218, 4'hf, 32'hffffffff);
        rd_exp(12'h20c, 32'h00010004);
        rd_exp(12'h218, 32'h0);
        // Select the sustained entry, then park the host so a held write is not taken twice
        wr_sel(32'h1, 4'h1);
        u_cfg_host.op(1'b0, 1'b0, 12'h0, 4'h0, 32'h0);
        lmaxv <= descriptor_t'(21'($urandom()));
        lsusv <= descriptor_t'(21'($urandom()));
        {lmax, lsus, lal, lalv} <= 4'hf;
        @(posedge clk);
        {lmax, lsus, lal} <= 3'h0;
        rd_exp(12'h214, {11'h0, lsusv});
        wr_sel(32'h0, 4'h1);
        dm = lmaxv;
        dm.sub_state = 3'h0;
        dm.rail = 3'h2;
        rd_exp(12'h214, {11'h0, dm});
        rd_exp(12'h218, 32'h1);
        u_cfg_host.op(1'b0, 1'b0, 12'h0, 4'h0, 32'h0);
        repeat (3) @(posedge clk);
        // Mid-run reset drops every loaded value back to its default
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        dm = '{3'h2, 3'h7, 2'h0, 3'h0, 2'h0, 8'h04};
        rd_exp(12'h210, 32'h0);
        rd_exp(12'h214, {11'h0, dm});
        rd_exp(12'h218, 32'h0);
        wr_sel(32'h1, 4'h1);
        rd_exp(12'h214, {11'h0, SUS});
        u_cfg_host.op(1'b0, 1'b0, 12'h0, 4'h0, 32'h0);
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule : power_budget_capability_tb
`default_nettype wire
